/* core/bsp_slave_port.v */
// Sequencer bus slave port of the clock and bias board
`timescale 1ns/1ps
`include "bsp_consts.vh"
// Notes on behaviour
// - Type 00 is reset; device-address lines pick reboot or soft reset.
// - Type 01 reads one 32-bit word from the selected board.
// - Type 10 writes one 16-bit word to the selected board.
// - Type 11 writes one 32-bit word to the selected board.
// - Reset and writes take one cycle; a read takes three.
// - Reset with all address lines high reboots and restores configuration defaults.
// - Reset with all address lines low clears functional state, keeps configuration.
// - Read address comes from data lines 15:0 while selected.
// - One clock after taking address, register contents drive the return bus.
// - Cycle after data is driven, master latches and device releases bus.
// - 32-bit writes reach only addresses 0x0000 to 0x003F.
// - 32-bit write: address from device-address lines, all 32 data bits stored.
// - 16-bit write: address from data 31:16, value from data 15:0.
// - Acknowledge strobe is neither driven nor used.
// - Read data is one 32-bit value on the 48-bit return bus.
// - Indicator dark until logic has booted and runs.
// - Indicator lit after boot until first valid access, then off until programmed.
// - Indicator bit 0 shows select activity, bit 1 forces on, bit 2 off.
// - Active-low shutdown input opens every bias and clock enable switch.
// - Each monitor output has its own selector over the 32 clocks.
// - Everything is synchronous to the rising edge of the board clock.

module bsp_slave_port #(
  parameter BOOT_CYCLES = `BSP_BOOT_CYCLES
) (
  input wire SYS_CLK,
  input wire RST_N,
  input wire BOARD_SEL_N,
  input wire [1:0] TRANSACTION_TYPE_LINES,
  input wire [5:0] DEVICE_ADDRESS_LINES,
  input wire [31:0] SEQUENCER_DATA_LINES,
  input wire SHUTDOWN_N,
  output reg [47:0] RETURN_DATA_BUS,
  output reg RETURN_DATA_OE,
  output reg REBOOT_REQUEST,
  output reg DIAG_INDICATOR,
  output reg [31:0] CLOCK_LEVELS,
  output reg BIAS_ENABLE,
  output reg CLOCK_ENABLE,
  output wire MONITOR_A,
  output wire MONITOR_B
);

  // ==========================================
  // Read-state codes
  localparam ST_IDLE = 2'b00;
  localparam ST_DRIVE = 2'b01;
  localparam ST_RELEASE = 2'b10;

  // ==========================================
  // Decoding of the bus type, used by the indicator process
  function is_access;
    input [1:0] tt;
    begin
      is_access = (tt != `BSP_TT_RESET);
    end
  endfunction

  // Register read decode
  function [31:0] read_mux;
    input [15:0] addr;
    input [31:0] lvl;
    input [15:0] gen;
    input [15:0] mux;
    input [15:0] ind;
    begin
      case (addr)
        `BSP_REG_CLKPORT: read_mux = lvl;
        `BSP_REG_GLOBAL_ENBL: read_mux = {16'h0000, gen};
        `BSP_REG_MUXSLCT: read_mux = {16'h0000, mux};
        `BSP_REG_INDICATOR: read_mux = {16'h0000, ind};
        default: read_mux = 32'h00000000;
      endcase
    end
  endfunction

  // ==========================================
  // Pin synchronisers: two flops before any logic looks at a pin
  // The bus is launched on the same board clock but still arrives on pins,
  // so every transaction is seen two clocks late by the decode below
  reg [1:0] sync_sel_n;
  reg [1:0] sync_tt0;
  reg [1:0] sync_tt1;
  reg [1:0] sync_shut_n;
  reg [5:0] meta_devaddr;
  reg [5:0] sync_devaddr;
  reg [31:0] meta_data;
  reg [31:0] sync_data;

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_sel_n <= 2'b11;
      sync_tt0 <= 2'b00;
      sync_tt1 <= 2'b00;
      sync_shut_n <= 2'b11;
      meta_devaddr <= 6'h00;
      sync_devaddr <= 6'h00;
      meta_data <= 32'h00000000;
      sync_data <= 32'h00000000;
    end else begin
      sync_sel_n <= {sync_sel_n[0], BOARD_SEL_N};
      sync_tt0 <= {sync_tt0[0], TRANSACTION_TYPE_LINES[0]};
      sync_tt1 <= {sync_tt1[0], TRANSACTION_TYPE_LINES[1]};
      sync_shut_n <= {sync_shut_n[0], SHUTDOWN_N};
      meta_devaddr <= DEVICE_ADDRESS_LINES;
      sync_devaddr <= meta_devaddr;
      meta_data <= SEQUENCER_DATA_LINES;
      sync_data <= meta_data;
    end
  end

  wire sel = ~sync_sel_n[1];
  wire [1:0] tt = {sync_tt1[1], sync_tt0[1]};
  wire shut = ~sync_shut_n[1];

  // ==========================================
  // Boot timer: logic counts as booted once the boot time has passed
  reg [`BSP_CNT_W-1:0] boot_cnt;
  reg booted;
  // Counter widened to the parameter's 32 bits for the compare, so the short
  // simulation value and the full boot time share one expression
  wire [31:0] boot_cnt_wide = {{(32-`BSP_CNT_W){1'b0}}, boot_cnt};
  wire boot_done = (boot_cnt_wide >= BOOT_CYCLES - 1);

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      boot_cnt <= {`BSP_CNT_W{1'b0}};
      booted <= 1'b0;
    end else if (!booted) begin
      if (boot_done) begin
        booted <= 1'b1;
      end
      boot_cnt <= boot_cnt + 1'b1;
    end
  end

  // ==========================================
  // Transaction decode; a deselected cycle decodes to nothing
  wire start = sel && booted;
  wire rst_txn = start && (tt == `BSP_TT_RESET);
  wire do_reboot = rst_txn && (sync_devaddr == `BSP_DEVA_REBOOT);
  wire do_soft = rst_txn && (sync_devaddr == `BSP_DEVA_SOFT);
  wire wr16 = start && (tt == `BSP_TT_WR16);
  wire wr32 = start && (tt == `BSP_TT_WR32);
  wire [15:0] wr16_addr = sync_data[31:16];
  wire [15:0] wr16_val = sync_data[15:0];
  // Reset selectors other than all-high or all-low fall through and do nothing
  // Device-address lines only span 0x00..0x3f, the wide-write window
  wire [15:0] wr32_addr = {10'h000, sync_devaddr};

  // ==========================================
  // Configuration registers, returned to defaults only by reboot
  reg [15:0] gen_enbl;
  reg [15:0] mux_sel;
  reg [15:0] ind_ctl;

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CLOCK_LEVELS <= `BSP_RST_CLKPORT;
      gen_enbl <= `BSP_RST_GEN;
      mux_sel <= `BSP_RST_MUX;
      ind_ctl <= `BSP_RST_IND;
    end else if (do_reboot) begin
      CLOCK_LEVELS <= `BSP_RST_CLKPORT;
      gen_enbl <= `BSP_RST_GEN;
      mux_sel <= `BSP_RST_MUX;
      ind_ctl <= `BSP_RST_IND;
    end else if (wr32 && wr32_addr <= `BSP_WIDE_LAST) begin
      if (wr32_addr == `BSP_REG_CLKPORT) begin
        CLOCK_LEVELS <= sync_data;
      end
    end else if (wr16) begin
      case (wr16_addr)
        `BSP_REG_GLOBAL_ENBL: gen_enbl <= wr16_val;
        `BSP_REG_MUXSLCT: mux_sel <= wr16_val;
        `BSP_REG_INDICATOR: ind_ctl <= wr16_val;
        default: gen_enbl <= gen_enbl;
      endcase
    end
  end

  // ==========================================
  // Reboot request pulse, for the boot-memory loader
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REBOOT_REQUEST <= 1'b0;
    end else begin
      REBOOT_REQUEST <= do_reboot;
    end
  end

  // ==========================================
  // Read sequencer: address cycle, drive cycle, release cycle.
  // Functional state, so soft reset and reboot both clear it.
  // Requests are not looked at during the drive and release cycles, where
  // the master still holds select for the same read.
  reg [1:0] rd_state;
  reg [15:0] rd_addr;

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_state <= ST_IDLE;
      rd_addr <= 16'h0000;
      RETURN_DATA_BUS <= 48'h000000000000;
      RETURN_DATA_OE <= 1'b0;
    end else if (do_soft || do_reboot) begin
      rd_state <= ST_IDLE;
      RETURN_DATA_OE <= 1'b0;
      RETURN_DATA_BUS <= 48'h000000000000;
    end else begin
      case (rd_state)
        ST_IDLE: begin
          RETURN_DATA_OE <= 1'b0;
          if (start && tt == `BSP_TT_READ) begin
            rd_addr <= sync_data[15:0];
            rd_state <= ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          // Upper 16 lanes stay zero: one 32-bit value per transfer
          RETURN_DATA_BUS <= {16'h0000,
            read_mux(rd_addr, CLOCK_LEVELS, gen_enbl, mux_sel, ind_ctl)};
          RETURN_DATA_OE <= 1'b1;
          rd_state <= ST_RELEASE;
        end
        ST_RELEASE: begin
          RETURN_DATA_OE <= 1'b0;
          rd_state <= ST_IDLE;
        end
        default: begin
          rd_state <= ST_IDLE;
          RETURN_DATA_OE <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Diagnostic indicator: dark while booting, lit until first access,
  // then follows the control register. Force-off beats force-on.
  // The activity bit follows the synchronised select, one clock behind it.
  reg seen_access;

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      seen_access <= 1'b0;
      DIAG_INDICATOR <= 1'b0;
    end else begin
      if (start && is_access(tt)) begin
        seen_access <= 1'b1;
      end
      if (!booted) begin
        DIAG_INDICATOR <= 1'b0;
      end else if (!seen_access) begin
        DIAG_INDICATOR <= 1'b1;
      end else if (ind_ctl[`BSP_IND_FORCE_OFF]) begin
        DIAG_INDICATOR <= 1'b0;
      end else if (ind_ctl[`BSP_IND_FORCE_ON]) begin
        DIAG_INDICATOR <= 1'b1;
      end else begin
        DIAG_INDICATOR <= ind_ctl[`BSP_IND_ACTIVITY] & sel;
      end
    end
  end

  // ==========================================
  // Output isolation: shutdown overrides software enables
  // Shutdown passes the pin synchroniser, so isolation lags the pin by three
  // clocks; the trade buys freedom from metastable enable glitches
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BIAS_ENABLE <= 1'b0;
      CLOCK_ENABLE <= 1'b0;
    end else begin
      BIAS_ENABLE <= gen_enbl[`BSP_GEN_BIAS] & ~shut;
      CLOCK_ENABLE <= gen_enbl[`BSP_GEN_CLOCK] & ~shut;
    end
  end

  // ==========================================
  // Front-panel monitor selectors; each output is a flop in the child
  bsp_clock_monitor u_mon_a (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .clocks(CLOCK_LEVELS),
    .select(mux_sel[`BSP_MUX_A_LSB +: `BSP_SEL_W]),
    .monitor(MONITOR_A)
  );

  bsp_clock_monitor u_mon_b (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .clocks(CLOCK_LEVELS),
    .select(mux_sel[`BSP_MUX_B_LSB +: `BSP_SEL_W]),
    .monitor(MONITOR_B)
  );

  // The acknowledge strobe has no port at all.

endmodule

/* include/bsp_consts.vh */
// Constants for the backplane sequencer slave port
`ifndef BSP_CONSTS_VH
`define BSP_CONSTS_VH

// ==========================================
// Transaction type codes
`define BSP_TT_RESET 2'b00
`define BSP_TT_READ 2'b01
`define BSP_TT_WR16 2'b10
`define BSP_TT_WR32 2'b11

// ==========================================
// Reset selectors on the device-address lines
`define BSP_DEVA_REBOOT 6'h3f
`define BSP_DEVA_SOFT 6'h00

// ==========================================
// Register map (16-bit word addresses)
`define BSP_REG_CLKPORT 16'h0000
`define BSP_REG_GLOBAL_ENBL 16'h016e
`define BSP_REG_MUXSLCT 16'h016f
`define BSP_REG_INDICATOR 16'h0200
`define BSP_WIDE_LAST 16'h003f

// ==========================================
// Field positions and reset values
`define BSP_IND_ACTIVITY 0
`define BSP_IND_FORCE_ON 1
`define BSP_IND_FORCE_OFF 2
`define BSP_MUX_A_LSB 0
`define BSP_MUX_B_LSB 5
`define BSP_SEL_W 5
`define BSP_GEN_BIAS 0
`define BSP_GEN_CLOCK 1
`define BSP_RST_CLKPORT 32'h00000000
`define BSP_RST_IND 16'h0000
`define BSP_RST_MUX 16'h0000
`define BSP_RST_GEN 16'h0000

// ==========================================
// Timing
`define BSP_BOOT_MS 30
`define BSP_CLK_MHZ 100
`define BSP_BOOT_CYCLES (`BSP_BOOT_MS * 1000 * `BSP_CLK_MHZ)
`define BSP_CNT_W 22

`endif

/* core/bsp_clock_monitor.v */
// Clock monitor multiplexer: routes one of the 32 clock outputs to a test point
`timescale 1ns/1ps
`include "bsp_consts.vh"

module bsp_clock_monitor (
  input wire clk,
  input wire rst_n,
  input wire [31:0] clocks,
  input wire [`BSP_SEL_W-1:0] select,
  output reg monitor
);

  // ==========================================
  // Registered mux so the pin comes straight from a flop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor <= 1'b0;
    end else begin
      monitor <= clocks[select];
    end
  end

endmodule

/* bench/bsp_pixel_sink.sv */
// Behavioural model of the master's capture register on the return data bus
`timescale 1ns/1ps
module bsp_pixel_sink (
  input wire clk,
  input wire rst_n,
  input wire [47:0] bus,
  input wire oe,
  output reg [47:0] word,
  output reg valid
);
  // ==========================================
  // Capture
  // Latch only on rising edges while driven; stale bus values are never taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word <= 48'h0;
      valid <= 1'b0;
    end else begin
      valid <= oe;
      if (oe) begin
        word <= bus;
      end
    end
  end
endmodule

/* bench/bsp_port_props.sv */
// Concurrent checks on the pins of the sequencer slave port
`timescale 1ns/1ps
module bsp_port_props #(
  parameter BOOT_CYCLES = 20
) (
  input wire SYS_CLK,
  input wire RST_N,
  input wire BOARD_SEL_N,
  input wire [1:0] TRANSACTION_TYPE_LINES,
  input wire [5:0] DEVICE_ADDRESS_LINES,
  input wire SHUTDOWN_N,
  input wire [47:0] RETURN_DATA_BUS,
  input wire RETURN_DATA_OE,
  input wire REBOOT_REQUEST,
  input wire DIAG_INDICATOR,
  input wire [31:0] CLOCK_LEVELS,
  input wire BIAS_ENABLE,
  input wire CLOCK_ENABLE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  reg [31:0] up_cnt;
  // ==========================================
  // Cycles since reset release, saturating so it cannot wrap
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      up_cnt <= 32'h0;
    end else if (up_cnt < BOOT_CYCLES) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end
  // ==========================================
  // Properties
  a_oe_single_cycle: assert property (RETURN_DATA_OE |=> !RETURN_DATA_OE)
    else $error("return bus driven longer than one cycle");
  a_upper_bits_zero: assert property (RETURN_DATA_OE |-> RETURN_DATA_BUS[47:32] == 16'h0)
    else $error("upper return bits not zero");
  a_oe_from_read: assert property ($rose(RETURN_DATA_OE) |->
    $past(TRANSACTION_TYPE_LINES, 3) == 2'b01 && !$past(BOARD_SEL_N, 3))
    else $error("return bus driven without a read");
  a_reboot_cause: assert property (REBOOT_REQUEST |-> !$past(BOARD_SEL_N, 3) &&
    $past(TRANSACTION_TYPE_LINES, 3) == 2'b00 && $past(DEVICE_ADDRESS_LINES, 3) == 6'h3f)
    else $error("reboot without reboot transaction");
  a_bias_isolated: assert property (BIAS_ENABLE |-> $past(SHUTDOWN_N, 3))
    else $error("bias enabled during shutdown");
  a_clock_isolated: assert property (CLOCK_ENABLE |-> $past(SHUTDOWN_N, 3))
    else $error("clock enabled during shutdown");
  a_dark_before_boot: assert property (up_cnt < BOOT_CYCLES |-> !DIAG_INDICATOR)
    else $error("indicator lit before boot");
  a_idle_no_write: assert property (BOARD_SEL_N [*4] |-> $stable(CLOCK_LEVELS))
    else $error("register changed while not selected");
endmodule
bind bsp_slave_port bsp_port_props #(.BOOT_CYCLES(BOOT_CYCLES)) u_props (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .BOARD_SEL_N(BOARD_SEL_N),
  .TRANSACTION_TYPE_LINES(TRANSACTION_TYPE_LINES), .DEVICE_ADDRESS_LINES(DEVICE_ADDRESS_LINES),
  .SHUTDOWN_N(SHUTDOWN_N), .RETURN_DATA_BUS(RETURN_DATA_BUS), .RETURN_DATA_OE(RETURN_DATA_OE),
  .REBOOT_REQUEST(REBOOT_REQUEST), .DIAG_INDICATOR(DIAG_INDICATOR),
  .CLOCK_LEVELS(CLOCK_LEVELS), .BIAS_ENABLE(BIAS_ENABLE), .CLOCK_ENABLE(CLOCK_ENABLE));

/* bench/tb_top.sv */
// Self-checking bench for the sequencer slave port
`timescale 1ns/1ps
`include "bsp_consts.vh"
module tb_top;
  localparam BOOT = 20;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg sel_n = 1'b1;
  reg shut_n = 1'b1;
  reg [1:0] tt = 2'h0;
  reg [5:0] da = 6'h00;
  reg [31:0] sd = 32'h0;
  reg [31:0] lv;
  wire [47:0] rbus;
  wire [47:0] word;
  wire [31:0] lvl;
  wire oe, rbt, diag, bias_en, clk_en, mon_a, mon_b, got;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int reboots = 0;
  logic [47:0] expq[$];
  bsp_slave_port #(.BOOT_CYCLES(BOOT)) dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .BOARD_SEL_N(sel_n), .TRANSACTION_TYPE_LINES(tt), .DEVICE_ADDRESS_LINES(da),
    .SEQUENCER_DATA_LINES(sd), .SHUTDOWN_N(shut_n), .RETURN_DATA_BUS(rbus),
    .RETURN_DATA_OE(oe), .REBOOT_REQUEST(rbt), .DIAG_INDICATOR(diag), .CLOCK_LEVELS(lvl),
    .BIAS_ENABLE(bias_en), .CLOCK_ENABLE(clk_en), .MONITOR_A(mon_a), .MONITOR_B(mon_b));
  bsp_pixel_sink sink (.clk(sys_clk), .rst_n(rst_n), .bus(rbus), .oe(oe), .word(word),
    .valid(got));
  // ==========================================
  // Clock and reporting
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task check(input [47:0] seen, input [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Select held n cycles, then idle with random lines so unselected cycles are exercised
  task bus(input [1:0] t, input [5:0] a, input [31:0] d, input int n);
    @(negedge sys_clk);
    sel_n = 1'b0;
    tt = t;
    da = a;
    sd = d;
    repeat (n) @(negedge sys_clk);
    sel_n = 1'b1;
    {tt, da, sd} = 40'({$urandom, $urandom});
    repeat (5) @(negedge sys_clk);
  endtask
  // Read keeps select three cycles; upper data bits are noise the port must ignore
  task rd(input [15:0] a, input [31:0] e);
    expq.push_back({16'h0, e});
    bus(`BSP_TT_READ, 6'($urandom), ($urandom << 16) | a, 3);
  endtask
  // ==========================================
  // Result watcher and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (rbt) reboots++;
    if (got) check(word, expq.size() ? expq.pop_front() : ~word);
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end
  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(32'hfa82));
    lv = $urandom;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    check(diag, 0);
    repeat (BOOT + 4) @(negedge sys_clk);
    check(diag, 1);
    bus(`BSP_TT_WR32, 6'h00, lv, 1);
    check(lvl, lv);
    check(diag, 0);
    bus(`BSP_TT_WR32, 6'h01, ~lv, 1);
    check(lvl, lv);
    bus(`BSP_TT_WR16, 6'h00, {`BSP_REG_GLOBAL_ENBL, 16'h0003}, 1);
    check({bias_en, clk_en}, 2'b11);
    shut_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    check({bias_en, clk_en}, 2'b00);
    shut_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check({bias_en, clk_en}, 2'b11);
    bus(`BSP_TT_WR16, 6'h00, {`BSP_REG_MUXSLCT, 16'h0225}, 1);
    check({mon_a, mon_b}, {lv[5], lv[17]});
    rd(`BSP_REG_CLKPORT, lv);
    rd(`BSP_REG_GLOBAL_ENBL, 32'h3);
    rd(`BSP_REG_MUXSLCT, 32'h225);
    rd(16'h0123, 32'h0);
    // Force-off wins over force-on; activity bit stays dark while unselected
    for (int i = 0; i < 4; i++) begin
      bus(`BSP_TT_WR16, 6'h00, {`BSP_REG_INDICATOR, 16'h0006 >> i}, 1);
      check(diag, i == 1);
      if (i == 2) begin
        // Activity bit: lit while this board is selected, dark again after
        @(negedge sys_clk);
        sel_n = 1'b0;
        tt = `BSP_TT_WR16;
        sd = {16'h0123, 16'h0000};
        repeat (3) @(negedge sys_clk);
        check(diag, 1);
        sel_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        check(diag, 0);
      end
    end
    rd(`BSP_REG_INDICATOR, 32'h0);
    bus(`BSP_TT_RESET, `BSP_DEVA_SOFT, $urandom, 1);
    check({lvl, bias_en, clk_en}, {lv, 2'b11});
    bus(`BSP_TT_RESET, `BSP_DEVA_REBOOT, $urandom, 1);
    check(reboots, 1);
    check({lvl, bias_en, clk_en}, 34'h0);
    check(expq.size(), 0);
    summarize();
  end
endmodule
